// file: fmsc_defines.svh
// Address map, field positions, opcodes and reset values for the store/mode unit
`ifndef FMSC_DEFINES_SVH
`define FMSC_DEFINES_SVH

// Register byte addresses
`define FMSC_ADDR_CTRL     8'h00
`define FMSC_ADDR_INSTR    8'h04
`define FMSC_ADDR_ACC_SEL  8'h08
`define FMSC_ADDR_ACC_HI   8'h0c
`define FMSC_ADDR_ACC_LO   8'h10
`define FMSC_ADDR_DEST_HI  8'h14
`define FMSC_ADDR_DEST_LO  8'h18
`define FMSC_ADDR_STATUS   8'h1c

// Mode control bit positions
`define FMSC_CTRL_DPS      0
`define FMSC_CTRL_LIS      1
`define FMSC_CTRL_TSEL     2
`define FMSC_CTRL_OVTE     3
`define FMSC_CTRL_UVTE     4
`define FMSC_CTRL_W        5
`define FMSC_CTRL_RST      5'h00

// Status bit positions: result flags, trap, decode marks
`define FMSC_ST_C          0
`define FMSC_ST_V          1
`define FMSC_ST_Z          2
`define FMSC_ST_N          3
`define FMSC_ST_TRAP       4
`define FMSC_ST_F2I        5
`define FMSC_ST_BAD        6

// Whole-word opcodes and opcode groups in bits 15..8
`define FMSC_OP_SETF       16'hf001
`define FMSC_OP_SELECT_DOUBLE_OP       16'hf009
`define FMSC_OP_SELECT_SHORT_INT_OP       16'hf002
`define FMSC_OP_SELECT_LONG_INT_OP       16'hf00a
`define FMSC_GRP_STORE     8'hf8
`define FMSC_GRP_F2I       8'hfb
`define FMSC_GRP_CONV      8'hfc

// Floating field positions in a 64-bit accumulator, then the accumulator field of an instruction
`define FMSC_SIGN          63
`define FMSC_EXP_HI        62
`define FMSC_EXP_LO        55
`define FMSC_AC_HI         7
`define FMSC_AC_LO         6

// Bus answers
`define FMSC_RESP_OKAY     2'b00
`define FMSC_RESP_SLVERR   2'b10

`endif

// file: fmsc_host.sv
// Host-side AXI4-Lite master model that issues register accesses
`timescale 1ns/100ps
module fmsc_host (
  // Clock
  input  wire logic        clk,
  // Write channels
  output logic             awvalid,
  input  wire logic        awready,
  output logic [7:0]       awaddr,
  output logic [2:0]       awprot,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  // Read channels
  output logic             arvalid,
  input  wire logic        arready,
  output logic [7:0]       araddr,
  output logic [2:0]       arprot,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  // Answers are always accepted, so no response can stall
  assign bready = 1'b1;
  assign rready = 1'b1;
  assign awprot = 3'h0;
  assign arprot = 3'h0;
  assign wstrb  = 4'hf;

  // Idle bus from time zero
  initial begin
    awvalid = 1'b0;
    wvalid  = 1'b0;
    arvalid = 1'b0;
    awaddr  = 8'h00;
    araddr  = 8'h00;
    wdata   = 32'h0;
  end

  // Readies are registered, so the level at the falling edge is what the next edge sees
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_t;
    logic w_t;
    logic b_t;
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    b_t = 1'b0;
    while (!b_t) begin
      @(negedge clk);
      aw_t = awvalid & awready;
      w_t  = wvalid & wready;
      b_t  = bvalid;
      r    = bresp;
      @(posedge clk);
      // Released lines show the inverse so stale values never pass
      if (aw_t) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (w_t) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end
  endtask : wr

  // One read; the data word is taken at the edge where rvalid is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_t;
    logic r_t;
    araddr  <= a;
    arvalid <= 1'b1;
    r_t = 1'b0;
    while (!r_t) begin
      @(negedge clk);
      ar_t = arvalid & arready;
      r_t  = rvalid;
      d    = rdata;
      r    = rresp;
      @(posedge clk);
      if (ar_t) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
    end
  endtask : rd
endmodule : fmsc_host

// file: fmsc_pkg.sv
// Types shared by the store/mode unit
package fmsc_pkg;

  // Decoded instruction class
  typedef enum logic [3:0] {
    OP_NONE, OP_SETF, OP_SELECT_DOUBLE_OP, OP_SELECT_SHORT_INT_OP, OP_SELECT_LONG_INT_OP,
    OP_STORE, OP_CONV, OP_F2I, OP_BAD
  } fmsc_op_type;

endpackage : fmsc_pkg

// file: fmsc_top.sv
// Floating mode-set and store/convert unit with an AXI4-Lite register port
//
// Notes on behaviour
// - Select-double instruction sets double_precision_select to one.
// - Select-long instruction sets long_integer_select to one.
// - Select-short instruction clears long_integer_select.
// - Group 176 store widens when single mode, narrows when double mode.
// - Converting store of a zero accumulator writes exact zero.
// - Narrow, rounding, overflow trap off, rounding overflow: write exact zero.
// - Widening writes accumulator left-justified, lower half cleared.
// - Narrowing chops or rounds per truncate_select, then writes result.
// - Converting store: carry cleared, overflow on overflow, zero and negative.
// - Converting stores never raise the negative-zero trap.
// - No underflow on converting stores; no overflow when widening.
// - Trap enabled and narrowing overflows: write overflowed signed zero, trap.
// - Widening exact; narrowing error within one LSB chop, half rounding.
// - Group 174 copies accumulator unchanged at current precision, sets only zero and negative flags.
// - Plain stores never trap on negative zero and can store it.
// - Negative zero enters accumulator only with undefined-value trap off; the code strips it only from full-strobe writes of the high word.
// - Group 175 with accumulator field plus four is the float-to-int store.
// - long_integer_select zero means short, one means long integers.
// - truncate_select set chops, cleared rounds.
//
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`include "fmsc_defines.svh"

module fmsc_top (
  // Clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  // Write channels
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic [2:0]  AWPROT,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  // Read channels
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  input  wire logic [2:0]  ARPROT,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  // Trap request toward the processor
  output logic             TRAP_REQ
);

  logic                     awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [7:0]               awaddr_ff;
  logic [31:0]              wdata_ff, rdata_ff, wmask, nxt_rdata;
  logic [3:0]               wstrb_ff;
  logic [1:0]               bresp_ff, rresp_ff, nxt_rresp;
  logic                     do_wr, wr_hit, exec;
  logic [`FMSC_CTRL_W-1:0]  ctrl_ff;
  logic [1:0]               accsel_ff;
  logic [63:0]              acc_ff [4];
  logic [63:0]              dest_ff, acc_op, nxt_dest;
  logic [15:0]              instr;
  logic [6:0]               status_ff, nxt_status;
  fmsc_pkg::fmsc_op_type    op;
  logic                     acc_zero, ovf, tsel;
  logic [31:0]              rnd_sum, narrow_hi;

  // Byte-lane mask from the latched strobes
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign wmask[g*8 +: 8] = {8{wstrb_ff[g]}};
    end
  endgenerate

  // Write happens once both address and data are in and no answer is pending
  assign do_wr = !awready_ff && !wready_ff && !bvalid_ff; // Low ready means word held
  assign wr_hit = awaddr_ff <= `FMSC_ADDR_ACC_LO; // Writable words sit lowest in the map
  assign exec = do_wr && (awaddr_ff == `FMSC_ADDR_INSTR);
  assign instr = wdata_ff[15:0];
  // Write address and data taken in either order, one write at a time
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h0000_0000;
      wstrb_ff   <= 4'h0;
    end else if (bvalid_ff && BREADY) begin
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
    end else begin
      if (AWVALID && awready_ff) begin
        awready_ff <= 1'b0;
        awaddr_ff  <= {AWADDR[7:2], 2'b00};
      end
      if (WVALID && wready_ff) begin
        wready_ff <= 1'b0;
        wdata_ff  <= WDATA;
        wstrb_ff  <= WSTRB;
      end
    end
  end

  // Write response; unmapped or read-only offsets answer SLVERR
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= `FMSC_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? `FMSC_RESP_OKAY : `FMSC_RESP_SLVERR;
    end else if (bvalid_ff && BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end
  // Instruction decode; opcode groups live in bits 15..8
  always_comb begin
    op = fmsc_pkg::OP_BAD;
    if (instr == `FMSC_OP_SETF) begin
      op = fmsc_pkg::OP_SETF;
    end else if (instr == `FMSC_OP_SELECT_DOUBLE_OP) begin
      op = fmsc_pkg::OP_SELECT_DOUBLE_OP;
    end else if (instr == `FMSC_OP_SELECT_SHORT_INT_OP) begin
      op = fmsc_pkg::OP_SELECT_SHORT_INT_OP;
    end else if (instr == `FMSC_OP_SELECT_LONG_INT_OP) begin
      op = fmsc_pkg::OP_SELECT_LONG_INT_OP;
    end else if (instr[15:8] == `FMSC_GRP_STORE) begin
      op = fmsc_pkg::OP_STORE;
    end else if (instr[15:8] == `FMSC_GRP_CONV) begin
      op = fmsc_pkg::OP_CONV;
    end else if (instr[15:8] == `FMSC_GRP_F2I) begin
      op = fmsc_pkg::OP_F2I;
    end
  end
  // Mode bits: software writes them, mode instructions override
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      ctrl_ff <= `FMSC_CTRL_RST;
    end else if (do_wr && awaddr_ff == `FMSC_ADDR_CTRL && wstrb_ff[0]) begin
      ctrl_ff <= wdata_ff[`FMSC_CTRL_W-1:0];
    end else if (exec) begin
      case (op)
        fmsc_pkg::OP_SETF: ctrl_ff[`FMSC_CTRL_DPS] <= 1'b0;
        fmsc_pkg::OP_SELECT_DOUBLE_OP: ctrl_ff[`FMSC_CTRL_DPS] <= 1'b1;
        fmsc_pkg::OP_SELECT_LONG_INT_OP: ctrl_ff[`FMSC_CTRL_LIS] <= 1'b1;
        fmsc_pkg::OP_SELECT_SHORT_INT_OP: ctrl_ff[`FMSC_CTRL_LIS] <= 1'b0;
        default: ;
      endcase
    end
  end

  // Accumulator file loaded word by word; index picks the target
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      accsel_ff <= 2'b00;
      for (int i = 0; i < 4; i++) begin
        acc_ff[i] <= 64'h0;
      end
    end else if (do_wr) begin
      if (awaddr_ff == `FMSC_ADDR_ACC_SEL && wstrb_ff[0]) begin
        accsel_ff <= wdata_ff[1:0];
      end else if (awaddr_ff == `FMSC_ADDR_ACC_HI) begin
        acc_ff[accsel_ff][63:32] <= (acc_ff[accsel_ff][63:32] & ~wmask) | (wdata_ff & wmask);
        // A negative zero loaded by a full-strobe write becomes plain zero while that trap is on
        if (ctrl_ff[`FMSC_CTRL_UVTE] && wdata_ff[30:23] == 8'h00 && wstrb_ff == 4'hf) begin
          acc_ff[accsel_ff][`FMSC_SIGN] <= 1'b0;
        end
      end else if (awaddr_ff == `FMSC_ADDR_ACC_LO) begin
        acc_ff[accsel_ff][31:0] <= (acc_ff[accsel_ff][31:0] & ~wmask) | (wdata_ff & wmask);
      end
    end
  end

  // Operand and narrowing arithmetic
  assign acc_op = acc_ff[instr[`FMSC_AC_HI:`FMSC_AC_LO]];
  assign acc_zero = acc_op[`FMSC_EXP_HI:`FMSC_EXP_LO] == 8'h00;
  assign tsel = ctrl_ff[`FMSC_CTRL_TSEL];
  // Round adds the first dropped bit; carry may ripple into the exponent
  assign rnd_sum = {1'b0, acc_op[62:32]} + {31'h0, !tsel && acc_op[31]};
  assign ovf = rnd_sum[31]; // Exponent wrapped past its top
  assign narrow_hi = ovf ? (ctrl_ff[`FMSC_CTRL_OVTE] ? {acc_op[`FMSC_SIGN], 31'h0}
                                                     : 32'h0)
                         : {acc_op[`FMSC_SIGN], rnd_sum[30:0]};
  // Result and flags for the store family
  always_comb begin
    nxt_dest = dest_ff;
    nxt_status = status_ff;
    if (exec) begin
      nxt_status = 7'h00; // Negative-zero trap never raised here
      case (op)
        fmsc_pkg::OP_STORE: begin
          // Copy as is in double mode, high word with low word cleared in single mode, negative zero included
          nxt_dest = ctrl_ff[`FMSC_CTRL_DPS] ? acc_op : {acc_op[63:32], 32'h0};
          nxt_status[`FMSC_ST_Z] = acc_zero;
          nxt_status[`FMSC_ST_N] = acc_op[`FMSC_SIGN] && !acc_zero;
        end
        fmsc_pkg::OP_CONV: begin
          if (acc_zero) begin
            nxt_dest = 64'h0;
          end else if (!ctrl_ff[`FMSC_CTRL_DPS]) begin
            nxt_dest = {acc_op[63:32], 32'h0};
          end else begin
            nxt_dest = {narrow_hi, 32'h0};
          end
          nxt_status[`FMSC_ST_V] = ctrl_ff[`FMSC_CTRL_DPS] && !acc_zero && ovf;
          nxt_status[`FMSC_ST_TRAP] = ctrl_ff[`FMSC_CTRL_DPS] && !acc_zero && ovf &&
                                      ctrl_ff[`FMSC_CTRL_OVTE];
          nxt_status[`FMSC_ST_Z] = acc_zero;
          nxt_status[`FMSC_ST_N] = acc_op[`FMSC_SIGN] && !acc_zero;
        end
        fmsc_pkg::OP_F2I: nxt_status[`FMSC_ST_F2I] = 1'b1;
        fmsc_pkg::OP_BAD: nxt_status[`FMSC_ST_BAD] = 1'b1;
        default: nxt_status = 7'h00;
      endcase
    end
  end
  // Destination and status hold the last executed instruction
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      dest_ff   <= 64'h0;
      status_ff <= 7'h00;
      TRAP_REQ  <= 1'b0;
    end else begin
      dest_ff   <= nxt_dest;
      status_ff <= nxt_status;
      TRAP_REQ  <= exec && nxt_status[`FMSC_ST_TRAP];
    end
  end

  // Read mux; reads have no side effects
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `FMSC_RESP_OKAY;
    if (ARADDR[7:2] == `FMSC_ADDR_CTRL >> 2) begin
      nxt_rdata = {27'h0, ctrl_ff};
    end else if (ARADDR[7:2] == `FMSC_ADDR_INSTR >> 2) begin
      nxt_rdata = 32'h0000_0000;
    end else if (ARADDR[7:2] == `FMSC_ADDR_ACC_SEL >> 2) begin
      nxt_rdata = {30'h0, accsel_ff};
    end else if (ARADDR[7:2] == `FMSC_ADDR_ACC_HI >> 2) begin
      nxt_rdata = acc_ff[accsel_ff][63:32];
    end else if (ARADDR[7:2] == `FMSC_ADDR_ACC_LO >> 2) begin
      nxt_rdata = acc_ff[accsel_ff][31:0];
    end else if (ARADDR[7:2] == `FMSC_ADDR_DEST_HI >> 2) begin
      nxt_rdata = dest_ff[63:32];
    end else if (ARADDR[7:2] == `FMSC_ADDR_DEST_LO >> 2) begin
      nxt_rdata = dest_ff[31:0];
    end else if (ARADDR[7:2] == `FMSC_ADDR_STATUS >> 2) begin
      nxt_rdata = {25'h0, status_ff};
    end else begin
      nxt_rresp = `FMSC_RESP_SLVERR;
    end
  end

  // Read channel: one read in flight, answer one cycle after address
  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `FMSC_RESP_OKAY;
    end else if (ARVALID && arready_ff) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b1;
      rdata_ff   <= nxt_rdata;
      rresp_ff   <= nxt_rresp;
    end else if (rvalid_ff && RREADY) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
    end
  end

  assign AWREADY = awready_ff;
  assign WREADY  = wready_ff;
  assign BVALID  = bvalid_ff;
  assign BRESP   = bresp_ff;
  assign ARREADY = arready_ff;
  assign RVALID  = rvalid_ff;
  assign RDATA   = rdata_ff;
  assign RRESP   = rresp_ff;

  // Checks on the executing instruction
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  property p_select_double_op;
    exec && op == fmsc_pkg::OP_SELECT_DOUBLE_OP |=> ctrl_ff[`FMSC_CTRL_DPS] ##1 1'b1;
  endproperty
  a_select_double_op: assert property (p_select_double_op) else $error("double mode not set");
  property p_select_long_int_op;
    exec && op == fmsc_pkg::OP_SELECT_LONG_INT_OP |=> ctrl_ff[`FMSC_CTRL_LIS];
  endproperty
  a_select_long_int_op: assert property (p_select_long_int_op) else $error("long mode not set");
  property p_select_short_int_op;
    exec && op == fmsc_pkg::OP_SELECT_SHORT_INT_OP |=> !ctrl_ff[`FMSC_CTRL_LIS];
  endproperty
  a_select_short_int_op: assert property (p_select_short_int_op) else $error("short mode not set");
  property p_conv_zero;
    exec && op == fmsc_pkg::OP_CONV && acc_zero |=> dest_ff == 64'h0 && status_ff[`FMSC_ST_Z];
  endproperty
  a_conv_zero: assert property (p_conv_zero) else $error("zero store not exact");
  property p_ovf_zero;
    exec && op == fmsc_pkg::OP_CONV && ctrl_ff[`FMSC_CTRL_DPS] && !acc_zero && ovf &&
    !ctrl_ff[`FMSC_CTRL_OVTE] |=> dest_ff == 64'h0 && status_ff[`FMSC_ST_V] && !TRAP_REQ;
  endproperty
  a_ovf_zero: assert property (p_ovf_zero) else $error("overflow not zeroed");
  property p_widen;
    exec && op == fmsc_pkg::OP_CONV && !ctrl_ff[`FMSC_CTRL_DPS] && !acc_zero
    |=> dest_ff == {$past(acc_op[63:32]), 32'h0} && !status_ff[`FMSC_ST_V];
  endproperty
  a_widen: assert property (p_widen) else $error("widening wrong");
  property p_trap;
    exec && op == fmsc_pkg::OP_CONV && ctrl_ff[`FMSC_CTRL_DPS] && !acc_zero && ovf &&
    ctrl_ff[`FMSC_CTRL_OVTE] |=> TRAP_REQ && dest_ff[62:0] == 63'h0 ##1 !TRAP_REQ;
  endproperty
  a_trap: assert property (p_trap) else $error("overflow trap wrong");
  property p_carry;
    exec && (op == fmsc_pkg::OP_CONV || op == fmsc_pkg::OP_STORE) |=> !status_ff[`FMSC_ST_C];
  endproperty
  a_carry: assert property (p_carry) else $error("carry flag set");
  property p_store;
    exec && op == fmsc_pkg::OP_STORE && ctrl_ff[`FMSC_CTRL_DPS]
    |=> dest_ff == $past(acc_op) && !status_ff[`FMSC_ST_V] && !TRAP_REQ;
  endproperty
  a_store: assert property (p_store) else $error("plain store altered");

  c_widen: cover property (exec && op == fmsc_pkg::OP_CONV && !ctrl_ff[`FMSC_CTRL_DPS]);
  c_trap:  cover property (TRAP_REQ);
  c_store: cover property (exec && op == fmsc_pkg::OP_STORE);

endmodule : fmsc_top

// file: tb_top.sv
// Self-checking bench for the mode-set and store/convert unit
`timescale 1ns/100ps
`include "fmsc_defines.svh"
module tb_top;
  logic        ref_clk, reset, trap_req;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot;
  logic [31:0] wdata, rdata, rd_d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rd_r;
  int          err_total = 0;
  int          n_checks = 0;
  int          n_trap = 0;
  int          cyc = 0;
  logic [15:0] mop [4] = '{`FMSC_OP_SELECT_DOUBLE_OP, `FMSC_OP_SELECT_LONG_INT_OP, `FMSC_OP_SELECT_SHORT_INT_OP, `FMSC_OP_SETF};
  logic [7:0]  mctl [4] = '{8'h01, 8'h03, 8'h01, 8'h00};

  fmsc_top u_fmsc_top (
    .REF_CLK(ref_clk), .RESET(reset),
    .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr), .AWPROT(awprot),
    .WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(wstrb),
    .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
    .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr), .ARPROT(arprot),
    .RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp),
    .TRAP_REQ(trap_req)
  );

  fmsc_host u_fmsc_host (
    .clk(ref_clk),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
    .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
    .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
  );

  // 25 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Trap pulse count and hang guard, sampled mid-cycle where outputs are settled
  always @(negedge ref_clk) begin
    cyc++;
    if (trap_req === 1'b1) n_trap++;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end

  task automatic test_done();
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Register write expecting an OKAY answer
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    u_fmsc_host.wr(a, d, r);
    chk({30'h0, r}, {30'h0, `FMSC_RESP_OKAY});
  endtask : w

  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    u_fmsc_host.rd(a, d, r);
    chk(d, exp);
  endtask : rc

  task automatic ex(input logic [15:0] op);
    w(`FMSC_ADDR_INSTR, {16'h0, op});
  endtask : ex

  // Accumulator is loaded under the old mode, then the mode is set and the store runs
  task automatic cv(input logic [7:0] c, input logic [1:0] i, input logic [31:0] hi,
                    input logic [31:0] lo, input logic [31:0] eh, input logic cl,
                    input logic [7:0] st);
    w(`FMSC_ADDR_ACC_SEL, {30'h0, i});
    w(`FMSC_ADDR_ACC_HI, hi);
    w(`FMSC_ADDR_ACC_LO, lo);
    w(`FMSC_ADDR_CTRL, {24'h0, c});
    ex({`FMSC_GRP_CONV, i, 6'h0});
    rc(`FMSC_ADDR_DEST_HI, eh);
    if (cl) rc(`FMSC_ADDR_DEST_LO, 32'h0);
    rc(`FMSC_ADDR_STATUS, {24'h0, st});
  endtask : cv

  // Main sequence
  initial begin
    reset = 1'b1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rc(`FMSC_ADDR_CTRL, 32'h0);
    for (int k = 0; k < 4; k++) begin
      ex(mop[k]);
      rc(`FMSC_ADDR_CTRL, {24'h0, mctl[k]});
    end
    cv(8'h00, 2'd1, 32'hc0a00000, 32'h12345678, 32'hc0a00000, 1'b1, 8'h08);
    cv(8'h08, 2'd2, 32'h7fffffff, 32'hffffffff, 32'h7fffffff, 1'b1, 8'h00);
    cv(8'h01, 2'd2, 32'h00400000, 32'hffffffff, 32'h0, 1'b0, 8'h04);
    cv(8'h01, 2'd3, 32'h7fffffff, 32'h80000000, 32'h0, 1'b0, 8'h02);
    cv(8'h05, 2'd0, 32'h7fffffff, 32'h80000000, 32'h7fffffff, 1'b0, 8'h00);
    cv(8'h01, 2'd1, 32'h40800000, 32'h80000000, 32'h40800001, 1'b0, 8'h00);
    cv(8'h01, 2'd1, 32'h40800000, 32'h7fffffff, 32'h40800000, 1'b0, 8'h00);
    chk(n_trap, 32'd0);
    cv(8'h09, 2'd2, 32'hffffffff, 32'h80000000, 32'h80000000, 1'b0, 8'h1a);
    chk(n_trap, 32'd1);
    // Negative zero written as a full word only enters with the undefined-value trap off
    w(`FMSC_ADDR_CTRL, 32'h10);
    w(`FMSC_ADDR_ACC_SEL, 32'h0);
    w(`FMSC_ADDR_ACC_HI, 32'h80000000);
    rc(`FMSC_ADDR_ACC_HI, 32'h0);
    w(`FMSC_ADDR_CTRL, 32'h0);
    w(`FMSC_ADDR_ACC_HI, 32'h80000000);
    rc(`FMSC_ADDR_ACC_HI, 32'h80000000);
    cv(8'h11, 2'd0, 32'h80000000, 32'h0000abcd, 32'h0, 1'b0, 8'h04);
    ex({`FMSC_GRP_STORE, 8'h00});
    rc(`FMSC_ADDR_DEST_HI, 32'h80000000);
    rc(`FMSC_ADDR_DEST_LO, 32'h0000abcd);
    w(`FMSC_ADDR_CTRL, 32'h10);
    ex({`FMSC_GRP_STORE, 8'h00});
    rc(`FMSC_ADDR_DEST_HI, 32'h80000000);
    rc(`FMSC_ADDR_DEST_LO, 32'h0);
    ex({`FMSC_GRP_F2I, 8'hc0});
    rc(`FMSC_ADDR_STATUS, 32'h20);
    // Instruction field, not the access index, picks the source
    w(`FMSC_ADDR_ACC_SEL, 32'h3);
    ex({`FMSC_GRP_STORE, 8'h40});
    rc(`FMSC_ADDR_DEST_HI, 32'h40800000);
    // Unmapped and read-only places are refused
    u_fmsc_host.rd(8'h20, rd_d, rd_r);
    chk({30'h0, rd_r}, {30'h0, `FMSC_RESP_SLVERR});
    chk(rd_d, 32'h0);
    u_fmsc_host.wr(`FMSC_ADDR_DEST_HI, 32'h12345678, rd_r);
    chk({30'h0, rd_r}, {30'h0, `FMSC_RESP_SLVERR});
    rc(`FMSC_ADDR_DEST_HI, 32'h40800000);
    chk(n_trap, 32'd1);
    test_done();
  end
endmodule : tb_top
